// ===== rx_fmt_cfg.svh
// constants for the receive output status formatter
`ifndef RX_FMT_CFG_SVH
`define RX_FMT_CFG_SVH

// bypass mapping: raw bit a sits at bit 0, j at bit 9
`define RAW_A_BIT          0
`define RAW_B_BIT          1
`define RAW_DATA_LSB       2
`define STS_FLAG_BIT       2
`define STS_A_BIT          1
`define STS_B_BIT          0

// framing characters, both disparities, bit a in bit 0
`define K285_RD_NEG        10'h17C
`define K285_RD_POS        10'h283
`define COMMA_RD_NEG       8'h7C
`define COMMA_RD_POS       8'h83

// framer modes
`define FRM_LOW_LATENCY    2'h0
`define FRM_ALT_MULTI      2'h1
`define FRM_STD_MULTI      2'h2

// settings word after reset: raw path, K28.5, framer on, standard multi-byte
`define CFG_RESET          7'h16

// decoded-mode status codes
`define DST_DATA           3'h0
`define DST_SPECIAL        3'h1
`define DST_FRAMING        3'h3
`define DST_DISPARITY      3'h6
`define DST_VIOLATION      3'h7

// self-test status codes
`define BST_MATCH          3'h0
`define BST_LOOP_OK        3'h2
`define BST_LOOP_ERR       3'h4
`define BST_MISMATCH       3'h5
`define BST_AWAIT          3'h6
`define BST_START          3'h7

// self-test sequence and limits
`define ST_D00             8'h00
`define ST_ERR_MARGIN      5'h10
`define ST_RECENTER_CHARS  4'h9
`define ST_LFSR_SEED       9'h1FF

`endif

// ===== rx_fmt_pkg.sv
// types shared by the receive output status formatter
package rx_fmt_pkg;
  typedef enum logic [1:0] {ST_START, ST_AWAIT, ST_COMPARE} selftest_state_t;
  typedef logic [9:0] raw_char_t;
  typedef logic [2:0] status_t;
endpackage

// ===== sync_level.sv
// two-flop level synchroniser, async reset to zero
module sync_level #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ===== selftest_monitor.sv
// self-test compare state machine and its status code
`include "rx_fmt_cfg.svh"
module selftest_monitor
  import rx_fmt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       pll_locked,
  input  wire logic       ebuf_fault,
  input  wire logic [7:0] char_data,
  input  wire logic       char_special,
  output status_t         status_code,
  output logic            loop_done
);
  selftest_state_t state_q, state_d;
  logic [8:0] lfsr_q;
  logic [4:0] diff_q;
  logic [3:0] hold_q;
  logic       errs_q;
  status_t    code_q;
  logic       done_q;
  logic       match;
  logic       wrap;
  logic       start_seen;

  function automatic logic [8:0] lfsr_next(input logic [8:0] v);
    lfsr_next = {v[7:0], v[8] ^ v[4]};
  endfunction

  // expected data is the inverted register, so the seed yields D0.0
  assign match      = !char_special && (char_data == ~lfsr_q[7:0]);
  assign wrap       = (lfsr_next(lfsr_q) == `ST_LFSR_SEED);
  assign start_seen = !char_special && (char_data == `ST_D00);

  // next state; lock loss and buffer faults override everything
  always_comb begin
    state_d = state_q;
    if (!enable || !pll_locked || ebuf_fault || (hold_q != 4'h0)) begin
      state_d = ST_START;
    end else begin
      unique case (state_q)
        ST_START:   state_d = ST_AWAIT;
        ST_AWAIT:   if (start_seen) state_d = ST_COMPARE;
        ST_COMPARE: if (!match && (diff_q >= `ST_ERR_MARGIN)) state_d = ST_AWAIT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_q <= ST_START;
    else        state_q <= state_d;
  end

  // re-centre hold: start state is shown for nine characters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)               hold_q <= 4'h0;
    else if (ebuf_fault)      hold_q <= `ST_RECENTER_CHARS - 4'h1;
    else if (hold_q != 4'h0)  hold_q <= hold_q - 4'h1;
  end

  // sequence register and error-minus-match balance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= `ST_LFSR_SEED;
      diff_q <= 5'h00;
      errs_q <= 1'b0;
    end else if (state_d != ST_COMPARE) begin
      lfsr_q <= `ST_LFSR_SEED;
      diff_q <= 5'h00;
      errs_q <= 1'b0;
    end else if (state_q != ST_COMPARE) begin
      lfsr_q <= lfsr_next(`ST_LFSR_SEED);
      diff_q <= 5'h00;
      errs_q <= 1'b0;
    end else begin
      lfsr_q <= lfsr_next(lfsr_q);
      if (match) diff_q <= (diff_q == 5'h00) ? 5'h00 : diff_q - 5'h01;
      else       diff_q <= diff_q + 5'h01;
      errs_q <= wrap ? 1'b0 : (errs_q | !match);
    end
  end

  // alternate status encoding reports progress of the compare
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= `BST_START;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_d == ST_COMPARE) && (state_q == ST_COMPARE) && wrap;
      if (state_d == ST_START)                       code_q <= `BST_START;
      else if (state_d == ST_AWAIT)                  code_q <= `BST_AWAIT;
      else if (state_q != ST_COMPARE)                code_q <= `BST_MATCH;
      else if (wrap && (errs_q || !match))           code_q <= `BST_LOOP_ERR;
      else if (wrap)                                 code_q <= `BST_LOOP_OK;
      else if (match)                                code_q <= `BST_MATCH;
      else                                           code_q <= `BST_MISMATCH;
    end
  end

  assign status_code = code_q;
  assign loop_done   = done_q;
endmodule

// ===== rx_output_status_formatter.sv
// receive output register, framing flag, output clock alignment and status
`include "rx_fmt_cfg.svh"
module rx_output_status_formatter
  import rx_fmt_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  input  wire logic       decoder_bypass_select,
  input  wire logic       framing_pattern_select,
  input  wire logic       framer_enable,
  input  wire logic [1:0] framer_mode,
  input  wire logic       half_rate_enable,
  input  wire logic       selftest_enable,
  input  wire logic       pll_locked,
  input  wire logic [9:0] raw_char_bits,
  input  wire logic [7:0] dec_data,
  input  wire logic       dec_special,
  input  wire logic       dec_disparity_error,
  input  wire logic       dec_code_violation,
  input  wire logic       ebuf_fault,
  output logic [7:0]      rx_char_out,
  output logic [2:0]      rx_status_bits,
  output logic            framing_char_flag,
  output logic            rx_output_clock,
  output logic            selftest_loop_done
);

  //////////////////////////////////////////////////////////////////////////
  // system-side configuration holding registers

  logic [6:0] cfg_q;
  logic [6:0] cfg_d;
  logic [6:0] cfg_sync;
  logic [6:0] cfg_prev_q;
  logic [6:0] cfg_link_q;

  // gather settings into one word so they cross together as levels
  always_comb begin
    cfg_d = {selftest_enable, half_rate_enable, framer_mode,
             framer_enable, framing_pattern_select, decoder_bypass_select};
  end

  // reset values: raw path, K28.5 framing, standard multi-byte framer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cfg_q <= `CFG_RESET;
    else        cfg_q <= cfg_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // link-domain reset and synchronisers

  logic link_rst_n;
  logic lock_sync;

  // release of reset is synchronised to the link clock; assertion is async
  sync_level #(.W(1)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .din   (1'b1),
    .dout  (link_rst_n)
  );

  // settings are quasi-static; a change may take two link cycles to land
  sync_level #(.W(7)) u_cfg_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .din   (cfg_q),
    .dout  (cfg_sync)
  );

  // bits of one change may land an edge apart; a word is taken only once
  // two samples agree, so a mixed setting never reaches the link logic
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cfg_prev_q <= 7'h00;
      cfg_link_q <= 7'h00;
    end else begin
      cfg_prev_q <= cfg_sync;
      if (cfg_sync == cfg_prev_q) cfg_link_q <= cfg_sync;
    end
  end

  // lock indication comes from the analog loop, asynchronous to all
  sync_level #(.W(1)) u_lock_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .din   (pll_locked),
    .dout  (lock_sync)
  );

  logic       decoded_mode;
  logic       pattern_k285;
  logic       frm_on;
  logic [1:0] frm_mode;
  logic       half_rate;
  logic       st_on;

  assign decoded_mode = cfg_link_q[0];
  assign pattern_k285 = cfg_link_q[1];
  assign frm_on       = cfg_link_q[2];
  assign frm_mode     = cfg_link_q[4:3];
  assign half_rate    = cfg_link_q[5];
  assign st_on        = cfg_link_q[6];

  //////////////////////////////////////////////////////////////////////////
  // decode helpers

  // one function serves both pattern choices: K28.5 compares all ten bits, the comma only bits 7:0
  function automatic logic framing_match(input raw_char_t raw, input logic k285);
    logic hit_k;
    logic hit_c;
    hit_k = (raw == `K285_RD_NEG) || (raw == `K285_RD_POS);
    hit_c = (raw[7:0] == `COMMA_RD_NEG) || (raw[7:0] == `COMMA_RD_POS);
    framing_match = k285 ? hit_k : hit_c;
  endfunction

  // decoded status: violations outrank disparity, which outranks data
  function automatic status_t decoded_status(input logic cv, input logic rde,
                                             input logic frm, input logic spc);
    status_t s;
    s = `DST_DATA;
    if (cv)       s = `DST_VIOLATION;
    else if (rde) s = `DST_DISPARITY;
    else if (frm) s = `DST_FRAMING;
    else if (spc) s = `DST_SPECIAL;
    decoded_status = s;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // self-test compare

  status_t st_code;
  logic    st_done;

  selftest_monitor u_selftest (
    .clk          (link_clk),
    .rst_n        (link_rst_n),
    .enable       (st_on),
    .pll_locked   (lock_sync),
    .ebuf_fault   (ebuf_fault),
    .char_data    (dec_data),
    .char_special (dec_special),
    .status_code  (st_code),
    .loop_done    (st_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // stage 0: capture the framed character and its decode results

  raw_char_t s0_raw_q;
  logic [7:0] s0_data_q;
  status_t    s0_dst_q;
  logic       s0_flag_q;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s0_raw_q  <= 10'h000;
      s0_data_q <= 8'h00;
      s0_dst_q  <= `DST_DATA;
      s0_flag_q <= 1'b0;
    end else begin
      s0_raw_q  <= raw_char_bits;
      s0_data_q <= dec_data;
      s0_flag_q <= framing_match(raw_char_bits, pattern_k285);
      s0_dst_q  <= decoded_status(dec_code_violation, dec_disparity_error,
                                  framing_match(raw_char_bits, pattern_k285),
                                  dec_special);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stage 1: optional extra pipeline stage used for alignment

  raw_char_t s1_raw_q;
  logic [7:0] s1_data_q;
  status_t    s1_dst_q;
  status_t    s1_st_q;
  logic       s1_flag_q;

  // self-test code is already one stage late, so it lines up with stage 0
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s1_raw_q  <= 10'h000;
      s1_data_q <= 8'h00;
      s1_dst_q  <= `DST_DATA;
      s1_st_q   <= `BST_START;
      s1_flag_q <= 1'b0;
    end else begin
      s1_raw_q  <= s0_raw_q;
      s1_data_q <= s0_data_q;
      s1_dst_q  <= s0_dst_q;
      s1_st_q   <= st_code;
      s1_flag_q <= s0_flag_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // half-rate output clock and boundary alignment

  logic phase_q;
  logic phase_d;
  logic extra_q;
  logic extra_d;
  logic low_lat;
  logic multi;
  logic align;

  assign low_lat = frm_on && (frm_mode == `FRM_LOW_LATENCY);
  assign multi   = frm_on && ((frm_mode == `FRM_ALT_MULTI) ||
                              (frm_mode == `FRM_STD_MULTI));
  assign align   = half_rate && s0_flag_q;

  // low latency: flag loads one edge later from stage 1; holding the clock
  // low here stretches it so the next edge is a rising one
  always_comb begin
    phase_d = !phase_q;
    if (align && low_lat) begin
      phase_d = 1'b0;
    end
  end

  // multi-byte: clock keeps its phase, the data path gains or drops a stage
  // so the flagged character loads on a rising edge; a character repeats
  // or is skipped at that instant
  always_comb begin
    extra_d = extra_q;
    if (low_lat) begin
      extra_d = 1'b1;
    end else if (align && multi && (phase_q != extra_q)) begin
      extra_d = !extra_q;
    end
    // framer off: stage choice and clock are left as they are
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) phase_q <= 1'b0;
    else             phase_q <= phase_d;
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) extra_q <= 1'b0;
    else             extra_q <= extra_d;
  end

  assign rx_output_clock = phase_q; // one clocking scheme for both ends

  //////////////////////////////////////////////////////////////////////////
  // output register

  raw_char_t  sel_raw;
  logic [7:0] sel_data;
  status_t    sel_dst;
  status_t    sel_st;
  logic       sel_flag;
  logic [7:0] out_data_d;
  status_t    out_sts_d;

  // source chosen with the next stage setting so a flip acts at once
  always_comb begin
    sel_raw  = extra_d ? s1_raw_q  : s0_raw_q;
    sel_data = extra_d ? s1_data_q : s0_data_q;
    sel_dst  = extra_d ? s1_dst_q  : s0_dst_q;
    sel_st   = extra_d ? s1_st_q   : st_code;
    sel_flag = extra_d ? s1_flag_q : s0_flag_q;
  end

  // bypass presents the raw bits; decoded mode the data and status
  always_comb begin
    out_data_d = sel_raw[`RAW_DATA_LSB +: 8];
    out_sts_d  = 3'h0;
    out_sts_d[`STS_FLAG_BIT] = sel_flag;
    out_sts_d[`STS_A_BIT]    = sel_raw[`RAW_A_BIT];
    out_sts_d[`STS_B_BIT]    = sel_raw[`RAW_B_BIT];
    if (decoded_mode) begin
      out_data_d = sel_data;
      out_sts_d  = st_on ? sel_st : sel_dst;
    end
  end

  logic [7:0] out_data_q;
  status_t    out_sts_q;
  logic       out_flag_q;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_data_q <= 8'h00;
      out_sts_q  <= 3'h0;
      out_flag_q <= 1'b0;
    end else begin
      out_data_q <= out_data_d;
      out_sts_q  <= out_sts_d;
      out_flag_q <= sel_flag;
    end
  end

  assign rx_char_out       = out_data_q;
  assign rx_status_bits    = out_sts_q;
  assign framing_char_flag = out_flag_q;

  //////////////////////////////////////////////////////////////////////////
  // loop completion event back to the system clock

  logic done_tgl_q;
  logic done_sync;
  logic done_seen_q;
  logic loop_pulse_q;

  // a toggle survives the slower-to-faster crossing without a handshake
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n)  done_tgl_q <= 1'b0;
    else if (st_done) done_tgl_q <= !done_tgl_q;
  end

  sync_level #(.W(1)) u_done_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .din   (done_tgl_q),
    .dout  (done_sync)
  );

  // one system-clock pulse per completed pass
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_seen_q  <= 1'b0;
      loop_pulse_q <= 1'b0;
    end else begin
      done_seen_q  <= done_sync;
      loop_pulse_q <= done_sync ^ done_seen_q;
    end
  end

  assign selftest_loop_done = loop_pulse_q;

endmodule

// ===== rx_fmt_checker_sva.sv
// concurrent checks on the receive output status formatter ports
`include "rx_fmt_cfg.svh"
module rx_fmt_checker
  import rx_fmt_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       link_clk,
  input wire logic       decoder_bypass_select,
  input wire logic       framing_pattern_select,
  input wire logic       framer_enable,
  input wire logic [1:0] framer_mode,
  input wire logic       half_rate_enable,
  input wire logic       selftest_enable,
  input wire logic       pll_locked,
  input wire logic [9:0] raw_char_bits,
  input wire logic [7:0] dec_data,
  input wire logic       dec_special,
  input wire logic       dec_disparity_error,
  input wire logic       dec_code_violation,
  input wire logic       ebuf_fault,
  input wire logic [7:0] rx_char_out,
  input wire logic [2:0] rx_status_bits,
  input wire logic       framing_char_flag,
  input wire logic       rx_output_clock,
  input wire logic       selftest_loop_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cfg_q;
  logic [5:0] calm_q;
  logic [3:0] unlock_q;
  logic [6:0] cfg_now;
  logic       calm;
  logic       st_on;
  logic [9:0] raw_out;
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // config crosses late, so judge only once it has sat still a while
  assign cfg_now = {decoder_bypass_select, framing_pattern_select, framer_enable,
                    framer_mode, half_rate_enable, selftest_enable};
  assign calm    = (calm_q == 6'h3F);
  assign st_on   = calm && decoder_bypass_select && selftest_enable;
  assign raw_out = {rx_char_out, rx_status_bits[0], rx_status_bits[1]};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q  <= '0;
      calm_q <= '0;
    end else begin
      cfg_q <= cfg_now;
      if (cfg_q != cfg_now) calm_q <= '0;
      else if (!calm) calm_q <= calm_q + 6'h01;
    end
  end
  // link edges since lock was lost, saturating
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) unlock_q <= '0;
    else if (pll_locked) unlock_q <= '0;
    else if (unlock_q != 4'hF) unlock_q <= unlock_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  flag_k285_a: assert property (calm && !decoder_bypass_select && framing_pattern_select
    && framing_char_flag |-> raw_out == `K285_RD_NEG || raw_out == `K285_RD_POS)
    else $error("flag set without k28.5 in output");
  flag_comma_a: assert property (calm && !decoder_bypass_select && !framing_pattern_select
    && framing_char_flag |-> raw_out[7:0] == `COMMA_RD_NEG || raw_out[7:0] == `COMMA_RD_POS)
    else $error("flag set without comma in output");
  bypass_path_a: assert property (calm && !decoder_bypass_select
    |-> raw_out == $past(raw_char_bits, 2) || raw_out == $past(raw_char_bits, 3))
    else $error("bypass output is not the raw character");
  decoded_path_a: assert property (calm && decoder_bypass_select && !selftest_enable
    |-> rx_char_out == $past(dec_data, 2) || rx_char_out == $past(dec_data, 3))
    else $error("decoded output is not the decoder data");
  violation_first_a: assert property (calm && decoder_bypass_select && !selftest_enable
    && $past(dec_code_violation, 2) && $past(dec_code_violation, 3)
    |-> rx_status_bits == `DST_VIOLATION) else $error("violation not reported first");
  lock_start_a: assert property (st_on && unlock_q >= 4'h6
    |-> rx_status_bits == `BST_START) else $error("lock loss did not force start");
  ebuf_hold_a: assert property (st_on && ebuf_fault
    |-> ##4 (rx_status_bits == `BST_START) [*5]) else $error("buffer fault did not hold start");
  clock_free_a: assert property (calm && !framer_enable
    |-> rx_output_clock != $past(rx_output_clock)) else $error("output clock adjusted while off");
  rise_on_flag_a: assert property (calm && framer_enable && half_rate_enable
    && framer_mode != 2'h3 && framing_char_flag |-> rx_output_clock && !$past(rx_output_clock))
    else $error("flagged character not on output clock rise");
endmodule

// ===== rx_host_capture.sv
// host receive logic model clocked by the link clock, sampling the forwarded output clock
module rx_host_capture (
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_output_clock,
  input  wire logic       framing_char_flag,
  input  wire logic [7:0] rx_char_out,
  output int              on_rise,
  output int              off_rise,
  output logic [7:0]      last_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  // tally where flagged characters fall; same clocking assumed both ends
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q    <= 1'b0;
      on_rise   <= 0;
      off_rise  <= 0;
      last_char <= 8'h00;
    end else begin
      prev_q <= rx_output_clock;
      // the host keeps a flagged character only on a true rising edge
      if (framing_char_flag && rx_output_clock && !prev_q) begin
        on_rise   <= on_rise + 1;
        last_char <= rx_char_out;
      end else if (framing_char_flag) off_rise <= off_rise + 1;
    end
  end
endmodule

// ===== rx_output_status_formatter_tb.sv
// self-checking bench for the receive output status formatter
`include "rx_fmt_cfg.svh"
module rx_output_status_formatter_tb
  import rx_fmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, link_clk = 0, decoder_bypass_select = 0, framing_pattern_select = 1;
  logic framer_enable = 1, half_rate_enable = 0, selftest_enable = 0, pll_locked = 1;
  logic dec_special = 0, dec_disparity_error = 0, dec_code_violation = 0, ebuf_fault = 0;
  logic [1:0] framer_mode = 2'h2;
  logic [9:0] raw_char_bits = '0;
  logic [7:0] dec_data = '0, rx_char_out, last_char;
  logic [2:0] rx_status_bits;
  logic framing_char_flag, rx_output_clock, selftest_loop_done, mon_on = 0;
  int bad_count = 0, checks = 0, ok_n = 0, mis_n = 0, done_n = 0, on_rise, off_rise, on0, off0;
  logic [9:0] raw_t [6] = '{10'h17C, 10'h283, 10'h27C, 10'h27C, 10'h383, 10'h155};
  logic       pat_t [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic       flg_t [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [2:0] df_t [5] = '{3'b000, 3'b100, 3'b010, 3'b111, 3'b100};
  logic [2:0] ds_t [5] = '{`DST_DATA, `DST_SPECIAL, `DST_DISPARITY, `DST_VIOLATION, `DST_FRAMING};
  always #2 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;
  rx_output_status_formatter dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .decoder_bypass_select(decoder_bypass_select), .framing_pattern_select(framing_pattern_select),
    .framer_enable(framer_enable), .framer_mode(framer_mode), .half_rate_enable(half_rate_enable),
    .selftest_enable(selftest_enable), .pll_locked(pll_locked), .raw_char_bits(raw_char_bits),
    .dec_data(dec_data), .dec_special(dec_special), .dec_disparity_error(dec_disparity_error),
    .dec_code_violation(dec_code_violation), .ebuf_fault(ebuf_fault), .rx_char_out(rx_char_out),
    .rx_status_bits(rx_status_bits), .framing_char_flag(framing_char_flag),
    .rx_output_clock(rx_output_clock), .selftest_loop_done(selftest_loop_done));
  rx_host_capture host_u (.link_clk(link_clk), .rst_n(rst_n), .rx_output_clock(rx_output_clock),
    .framing_char_flag(framing_char_flag), .rx_char_out(rx_char_out), .on_rise(on_rise),
    .off_rise(off_rise), .last_char(last_char));
  ////////////////////////////////////////////////////////////////////////////
  // self-test status tallies; loop done counted in the system domain
  always @(posedge link_clk) begin
    if (mon_on && rx_status_bits === `BST_LOOP_OK) ok_n++;
    if (mon_on && rx_status_bits === `BST_MISMATCH) mis_n++;
  end
  always @(posedge sys_clk) if (selftest_loop_done === 1'b1) done_n++;
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // config is quasi-static: change it, then let it cross and drain
  task automatic set_cfg(input logic [6:0] c);
    @(posedge sys_clk);
    {decoder_bypass_select, framing_pattern_select, framer_enable, framer_mode,
     half_rate_enable, selftest_enable} <= c;
    repeat (12) @(posedge link_clk);
  endtask
  task automatic put(input logic [9:0] r, input logic [7:0] d, input logic [2:0] f);
    @(posedge link_clk);
    raw_char_bits <= r;
    dec_data <= d;
    {dec_special, dec_disparity_error, dec_code_violation} <= f;
  endtask
  // latency is 2 or 3 edges, so search a short window for the character
  task automatic xfer(input string name, input logic [9:0] r, input logic [7:0] d,
                      input logic [2:0] f, input logic [7:0] eo, input logic [2:0] es, input logic ef);
    logic hit;
    hit = 0;
    put(r, d, f);
    put(r, d, f);
    repeat (6) begin
      put(10'h000, 8'h00, 3'b000);
      @(negedge link_clk);
      if (!hit && rx_char_out === eo) begin
        hit = 1;
        check({name, " status"}, {5'h00, es}, {5'h00, rx_status_bits});
        check({name, " flag"}, {7'h00, ef}, {7'h00, framing_char_flag});
      end
    end
    check({name, " seen"}, 8'h01, {7'h00, hit});
  endtask
  task automatic stream(input int n);
    logic [8:0] v;
    v = `ST_LFSR_SEED;
    repeat (n) begin
      put(10'h000, ~v[7:0], 3'b000);
      v = {v[7:0], v[8] ^ v[4]};
    end
  endtask
  task automatic expect_status(input string name, input logic [2:0] es);
    @(negedge link_clk);
    check(name, {5'h00, es}, {5'h00, rx_status_bits});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    bad_count++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end
  initial begin
    repeat (4) @(posedge link_clk);
    rst_n <= 1;
    repeat (4) @(posedge link_clk);
    for (int i = 0; i < 6; i++) begin
      set_cfg({1'b0, pat_t[i], 5'b0_11_0_0});
      xfer("bypass", raw_t[i], 8'h00, 3'b000, raw_t[i][9:2],
           {flg_t[i], raw_t[i][0], raw_t[i][1]}, flg_t[i]);
    end
    $display("test bypass done");
    set_cfg(7'b1_1_0_11_0_0);
    for (int i = 0; i < 5; i++)
      xfer("decoded", (i == 4) ? 10'h17C : 10'h000, 8'hA5 + 8'(i), df_t[i],
           8'hA5 + 8'(i), ds_t[i], i == 4);
    $display("test decoded done");
    put(10'h000, 8'h11, 3'b000); // no stray D0.0 while self-test starts
    set_cfg(7'b1_1_0_11_0_1);
    repeat (4) put(10'h000, 8'h11, 3'b000);
    expect_status("await", `BST_AWAIT);
    mon_on = 1;
    stream(1100);
    repeat (20) put(10'h000, 8'h11, 3'b100);
    check("loop ok", 8'd2, 8'(ok_n));
    check("loop pulses", 8'd2, 8'(done_n));
    check("errors", 8'h01, {7'h00, mis_n != 0});
    expect_status("resync", `BST_AWAIT);
    @(posedge link_clk);
    ebuf_fault <= 1'b1;
    @(posedge link_clk);
    ebuf_fault <= 1'b0;
    repeat (4) @(posedge link_clk);
    expect_status("buffer fault", `BST_START);
    repeat (20) @(posedge link_clk);
    pll_locked <= 1'b0;
    repeat (8) @(posedge link_clk);
    expect_status("lock loss", `BST_START);
    @(posedge link_clk);
    pll_locked <= 1'b1;
    mon_on = 0;
    $display("test selftest done");
    for (int m = 0; m < 4; m++) begin
      set_cfg({2'b01, m != 3, 2'(m), 2'b10});
      on0 = on_rise;
      off0 = off_rise;
      repeat (8) begin
        put(10'h17C, 8'h00, 3'b000);
        repeat (6) put(10'h000, 8'h00, 3'b000);
      end
      check("off edge flags", {7'h00, m == 3}, {7'h00, off_rise != off0});
      check("on edge flags", 8'h01, {7'h00, on_rise != on0});
      check("framed char", 8'h5F, last_char);
    end
    $display("test alignment done");
    close_out();
  end
endmodule
bind rx_output_status_formatter rx_fmt_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .link_clk(link_clk), .decoder_bypass_select(decoder_bypass_select),
  .framing_pattern_select(framing_pattern_select), .framer_enable(framer_enable),
  .framer_mode(framer_mode), .half_rate_enable(half_rate_enable),
  .selftest_enable(selftest_enable), .pll_locked(pll_locked), .raw_char_bits(raw_char_bits),
  .dec_data(dec_data), .dec_special(dec_special), .dec_disparity_error(dec_disparity_error),
  .dec_code_violation(dec_code_violation), .ebuf_fault(ebuf_fault), .rx_char_out(rx_char_out),
  .rx_status_bits(rx_status_bits), .framing_char_flag(framing_char_flag),
  .rx_output_clock(rx_output_clock), .selftest_loop_done(selftest_loop_done));
